//--- design/tpc_cfg.svh
// Constants for the timer prescaler and cascade block
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH

`define TPC_CNT_W        16
`define TPC_PRESC_DIV    20
`define TPC_PRESC_INIT   0
`define TPC_TC_COUNT     1
`define TPC_LOW_COUNT    2
`define TPC_CLR_W        2
`define TPC_CLR_BIT_C0   0
`define TPC_CLR_BIT_C1   1
`define TPC_OUT_RST      1'b0
`define TPC_IRQ_RST      1'b0

`endif

//--- design/tpc_counter.sv
// One programmable down counter with terminal-count event
`timescale 1ns/1ps
`include "tpc_cfg.svh"

module tpc_counter
  import tpc_pkg::*;
#(
  parameter int unsigned W = `TPC_CNT_W
) (
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_value,
  input  wire tpc_mode_t    mode,
  input  wire logic         gate,
  input  wire logic         count_tick,
  output logic              cnt_out,
  output logic              term_pulse
);

  logic [W-1:0] cnt_q,    cnt_d;
  logic [W-1:0] reload_q, reload_d;
  tpc_mode_t    mode_q,   mode_d;
  logic         out_q,    out_d;
  logic         term_q,   term_d;

  // Zero wraps to all ones, giving the full count range
  function automatic logic [W-1:0] dec_w(input logic [W-1:0] v);
    dec_w = v - W'(1);
  endfunction

  always_comb begin
    cnt_d    = cnt_q;
    reload_d = reload_q;
    mode_d   = mode_q;
    out_d    = out_q;
    term_d   = 1'b0;
    if (load) begin
      cnt_d    = load_value;
      reload_d = load_value;
      mode_d   = mode;
      out_d    = (mode == TPC_MODE_RATE);
    end else if (count_tick && gate) begin
      term_d = (cnt_q == W'(`TPC_TC_COUNT));
      unique case (mode_q)
        TPC_MODE_RATE: begin
          if (cnt_q == W'(`TPC_TC_COUNT)) begin
            cnt_d = reload_q;
            out_d = 1'b1;
          end else begin
            cnt_d = dec_w(cnt_q);
            if (cnt_q == W'(`TPC_LOW_COUNT)) begin
              out_d = 1'b0;
            end
          end
        end
        default: begin
          // Output stays high after terminal count until reloaded
          cnt_d = dec_w(cnt_q);
          if (cnt_q == W'(`TPC_TC_COUNT)) begin
            out_d = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q    <= '0;
      reload_q <= '0;
      mode_q   <= TPC_MODE_TERM;
      out_q    <= `TPC_OUT_RST;
      term_q   <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      reload_q <= reload_d;
      mode_q   <= mode_d;
      out_q    <= out_d;
      term_q   <= term_d;
    end
  end

  assign cnt_out    = out_q;
  assign term_pulse = term_q;

endmodule // tpc_counter

//--- design/tpc_pkg.sv
// Types shared by the timer prescaler and cascade block
package tpc_pkg;

  typedef enum logic [1:0] {
    TPC_MODE_TERM = 2'h0,
    TPC_MODE_RATE = 2'h2
  } tpc_mode_t;

endpackage

//--- design/tpc_top.sv
// Prescaler, three cascaded counters and latched terminal interrupts
`timescale 1ns/1ps
`include "tpc_cfg.svh"

module tpc_top
  import tpc_pkg::*;
#(
  parameter int unsigned W   = `TPC_CNT_W,
  parameter int unsigned DIV = `TPC_PRESC_DIV
) (
  input  wire logic                  core_clk,
  input  wire logic                  arst_n,
  input  wire logic [2:0]            load_strobe,
  input  wire logic [W-1:0]          load_value0,
  input  wire logic [W-1:0]          load_value1,
  input  wire logic [W-1:0]          load_value2,
  input  wire tpc_mode_t             mode0,
  input  wire tpc_mode_t             mode1,
  input  wire tpc_mode_t             mode2,
  input  wire logic [2:0]            gate,
  input  wire logic                  clr_wr,
  input  wire logic [`TPC_CLR_W-1:0] clr_data,
  output logic                       counter0_out,
  output logic                       counter1_out,
  output logic                       counter2_out,
  output logic                       counter0_terminal_irq,
  output logic                       counter1_terminal_irq
);

  localparam int unsigned PW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [PW-1:0] presc_q, presc_d;
  logic          tick;
  logic          c2_prev_q, c2_prev_d;
  logic          c2_rise;
  logic          c0_term, c1_term;
  logic          irq0_q, irq0_d;
  logic          irq1_q, irq1_d;
  logic          clr0, clr1;

  // Prescaler: tick on the last state, then restart
  assign tick = (presc_q == PW'(DIV - 1));

  always_comb begin
    if (tick) begin
      presc_d = PW'(`TPC_PRESC_INIT);
    end else begin
      presc_d = presc_q + PW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_q <= PW'(`TPC_PRESC_INIT);
    end else begin
      presc_q <= presc_d;
    end
  end

  // Single clock domain, so the cascade uses an edge enable, not a derived clock
  always_comb begin
    c2_prev_d = counter2_out;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      c2_prev_q <= `TPC_OUT_RST;
    end else begin
      c2_prev_q <= c2_prev_d;
    end
  end

  assign c2_rise = counter2_out & ~c2_prev_q;

  tpc_counter #(.W(W)) u_cnt2 (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .load       (load_strobe[2]),
    .load_value (load_value2),
    .mode       (mode2),
    .gate       (gate[2]),
    .count_tick (tick),
    .cnt_out    (counter2_out),
    .term_pulse ()
  );

  tpc_counter #(.W(W)) u_cnt0 (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .load       (load_strobe[0]),
    .load_value (load_value0),
    .mode       (mode0),
    .gate       (gate[0]),
    .count_tick (c2_rise),
    .cnt_out    (counter0_out),
    .term_pulse (c0_term)
  );

  tpc_counter #(.W(W)) u_cnt1 (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .load       (load_strobe[1]),
    .load_value (load_value1),
    .mode       (mode1),
    .gate       (gate[1]),
    .count_tick (c2_rise),
    .cnt_out    (counter1_out),
    .term_pulse (c1_term)
  );

  // Latches: a new terminal count beats a clear in the same cycle
  assign clr0 = clr_wr & clr_data[`TPC_CLR_BIT_C0];
  assign clr1 = clr_wr & clr_data[`TPC_CLR_BIT_C1];

  always_comb begin
    irq0_d = c0_term | (irq0_q & ~clr0);
    irq1_d = c1_term | (irq1_q & ~clr1);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq0_q <= `TPC_IRQ_RST;
      irq1_q <= `TPC_IRQ_RST;
    end else begin
      irq0_q <= irq0_d;
      irq1_q <= irq1_d;
    end
  end

  assign counter0_terminal_irq = irq0_q;
  assign counter1_terminal_irq = irq1_q;

  // Helper state seen only by the checks below
  logic [PW-1:0] since_rst_q, since_rst_d;
  logic [PW-1:0] gap_q,       gap_d;
  logic          seen_tick_q, seen_tick_d;

  // Gap counter kept apart from the prescaler, so a short period shows up
  always_comb begin
    since_rst_d = since_rst_q;
    seen_tick_d = seen_tick_q | tick;
    if (tick) begin
      gap_d = '0;
    end else begin
      gap_d = gap_q + PW'(1);
    end
    if (!seen_tick_q && !tick) begin
      since_rst_d = since_rst_q + PW'(1);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      since_rst_q <= '0;
      gap_q       <= '0;
      seen_tick_q <= 1'b0;
    end else begin
      since_rst_q <= since_rst_d;
      gap_q       <= gap_d;
      seen_tick_q <= seen_tick_d;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_presc_period: assert property (
    tick |-> ##DIV tick
  ) else $error("prescaler period is not the division ratio");

  a_presc_gap: assert property (
    tick |-> (gap_q == PW'(DIV - 1))
  ) else $error("prescaler ticked after a short gap");

  a_first_tick: assert property (
    (tick && !seen_tick_q) |-> (since_rst_q == PW'(DIV - 1))
  ) else $error("first tick after reset came at the wrong time");

  a_c2_clocked: assert property (
    ($changed(counter2_out) && !$past(load_strobe[2])) |-> $past(tick)
  ) else $error("counter 2 moved without a prescaler tick");

  a_c0_cascade: assert property (
    ($changed(counter0_out) && !$past(load_strobe[0])) |-> $past(c2_rise)
  ) else $error("counter 0 moved without a counter 2 edge");

  a_c1_cascade: assert property (
    ($changed(counter1_out) && !$past(load_strobe[1])) |-> $past(c2_rise)
  ) else $error("counter 1 moved without a counter 2 edge");

  a_irq0_set: assert property (
    c0_term |=> counter0_terminal_irq
  ) else $error("counter 0 terminal count did not latch");

  a_irq1_set: assert property (
    c1_term |=> counter1_terminal_irq
  ) else $error("counter 1 terminal count did not latch");

  a_irq0_hold: assert property (
    (counter0_terminal_irq && !clr0) |=> counter0_terminal_irq
  ) else $error("counter 0 interrupt dropped without a clear");

  a_irq1_clear: assert property (
    (counter1_terminal_irq && clr1 && !c1_term) |=> !counter1_terminal_irq
  ) else $error("counter 1 interrupt not cleared by clear bit");

  a_irq0_clear: assert property (
    (counter0_terminal_irq && clr0 && !c0_term) |=> !counter0_terminal_irq
  ) else $error("counter 0 interrupt not cleared by clear bit");

  a_irq1_hold: assert property (
    (counter1_terminal_irq && !clr1) |=> counter1_terminal_irq
  ) else $error("counter 1 interrupt dropped without a clear");

  c_c2_rise: cover property (c2_rise);
  c_irq0_raise: cover property ($rose(counter0_terminal_irq));
  c_irq1_clear: cover property ($fell(counter1_terminal_irq));
  c_set_vs_clr: cover property (c0_term && clr0);

endmodule // tpc_top

//--- testbench/timer_prescale_cascade_test.sv
// Self-checking bench for the prescaler, cascade and interrupt latches
`timescale 1ns/1ps
module timer_prescale_cascade_test;
  import tpc_pkg::*;
  localparam int unsigned DIV = 4;
  logic        core_clk    = 1'b0;
  logic        arst_n      = 1'b0;
  logic [2:0]  load_strobe = 3'h0;
  logic [15:0] v0          = 16'h0002;
  logic [15:0] v1          = 16'h0003;
  logic [15:0] v2          = 16'h0002;
  logic [2:0]  gate        = 3'h7;
  logic        clr_wr      = 1'b0;
  logic [1:0]  clr_data    = 2'h0;
  tpc_mode_t   m1          = TPC_MODE_TERM;
  logic        c0o, c1o, c2o, irq0, irq1;
  logic [2:0]  lvl;
  int          n_tests     = 0;
  int          n_mismatch  = 0;

  always #2 core_clk = ~core_clk;

  tpc_top #(.W(16), .DIV(DIV)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .load_strobe(load_strobe),
    .load_value0(v0), .load_value1(v1), .load_value2(v2),
    .mode0(TPC_MODE_TERM), .mode1(m1), .mode2(TPC_MODE_RATE),
    .gate(gate), .clr_wr(clr_wr), .clr_data(clr_data),
    .counter0_out(c0o), .counter1_out(c1o), .counter2_out(c2o),
    .counter0_terminal_irq(irq0), .counter1_terminal_irq(irq1));

  tpc_irq_mux_model mux (
    .core_clk(core_clk), .arst_n(arst_n), .counter0_terminal_irq(irq0),
    .counter1_terminal_irq(irq1), .irq_level(lvl));

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Cycles until the next rise of counter 2 output; bounded against a hang
  task automatic wait_c2_rise(output int cyc);
    cyc = 0;
    do begin
      step(1);
      cyc++;
    end while (c2o !== 1'b0 && cyc < 500);
    do begin
      step(1);
      cyc++;
    end while (c2o !== 1'b1 && cyc < 500);
    if (cyc >= 500) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  task automatic test_tick();
    int cyc;
    arst_n = 1'b0;
    step(3);
    arst_n = 1'b1;
    check({c0o, c1o, c2o, irq0, irq1}, 0);
    load_strobe = 3'h4;
    step(1);
    load_strobe = 3'h0;
    step(DIV - 2);
    check(c2o, 1);
    wait_c2_rise(cyc);
    check(cyc, DIV + 1);
    wait_c2_rise(cyc);
    check(cyc, 2 * DIV);
    $display("test_tick done");
  endtask

  task automatic test_cascade(input logic rate1);
    int cyc;
    step(2);
    m1          = rate1 ? TPC_MODE_RATE : TPC_MODE_TERM;
    load_strobe = 3'h3;
    step(1);
    load_strobe = 3'h0;
    for (int k = 1; k <= 3; k++) begin
      wait_c2_rise(cyc);
      step(DIV - 1);
      check(irq0, k >= 2);
      check(irq1, k >= 3);
      check(c0o, k >= 2);
      check(c1o, rate1 ? (k != 2) : (k >= 3));
      check(lvl, k >= 3 ? 3 : (k >= 2 ? 2 : 0));
    end
    $display("test_cascade done");
  endtask

  task automatic clear(input logic [1:0] bits);
    // Idle edge first, so a strobe just dropped is never raised again at once
    step(1);
    clr_wr   = 1'b1;
    clr_data = bits;
    step(1);
    clr_wr   = 1'b0;
    clr_data = 2'h0;
  endtask

  task automatic test_clear0_reset();
    clear(2'h0);
    check({irq1, irq0}, 2'h3);
    clear(2'h1);
    check({irq1, irq0}, 2'h2);
    step(3);
    check(irq1, 1);
    // Reset acts without waiting for a clock edge
    arst_n = 1'b0;
    #1;
    check({irq1, irq0, lvl}, 0);
    $display("test_clear0_reset done");
  endtask

  task automatic test_clear1();
    clear(2'h2);
    check({irq1, irq0}, 2'h1);
    check(lvl, 2);
    $display("test_clear1 done");
  endtask

  initial begin
    test_tick();
    test_cascade(1'b0);
    test_clear0_reset();
    test_tick();
    test_cascade(1'b1);
    test_clear1();
    tally_and_finish();
  end
endmodule // timer_prescale_cascade_test

//--- testbench/tpc_irq_mux_model.sv
// Interrupt multiplexor model fed by the two latched timer interrupts
`timescale 1ns/1ps
module tpc_irq_mux_model (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       counter0_terminal_irq,
  input  wire logic       counter1_terminal_irq,
  output logic      [2:0] irq_level
);
  // Plain level inputs; no latching here, the block already holds them
  always_comb begin
    irq_level = 3'h0;
    if (counter1_terminal_irq === 1'b1) begin
      irq_level = 3'h3;
    end else if (counter0_terminal_irq === 1'b1) begin
      irq_level = 3'h2;
    end
  end
endmodule // tpc_irq_mux_model
